// ==== include/fcr1_map.vh ====
// Constants for the first configuration register logic.
// Assumes a plain register port: address, wdata, write and read strobes.
`ifndef FCR1_MAP_VH
`define FCR1_MAP_VH

// Register offsets on the plain port
`define FCR1_ADDR_NV        4'h0
`define FCR1_ADDR_VOL       4'h1
`define FCR1_ADDR_LEGACY    4'h2
`define FCR1_ADDR_STATUS    4'h3
`define FCR1_ADDR_CTRL      4'h4

// Field positions in the configuration byte
`define FCR1_BIT_TLOCK      0
`define FCR1_BIT_QUAD       1
`define FCR1_BIT_PBLOC      2
`define FCR1_BIT_RSV3       3
`define FCR1_BIT_PLOCK      4
`define FCR1_BIT_PORIG      5
`define FCR1_BIT_SPLIT      6
`define FCR1_BIT_RSV7       7

// Bits guarded by the locks
`define FCR1_LOCKED_MASK    8'h64
// Bits that the nonvolatile copy accepts freely
`define FCR1_NV_FREE_MASK   8'h02
// Bits that the volatile copy accepts
`define FCR1_VOL_WR_MASK    8'h03
// Temporary lock bit alone
`define FCR1_TLOCK_MASK     8'h01

// Reset values
`define FCR1_RST_CFG        8'h00
`define FCR1_RST_LEGACY     3'h0

// Sector placement codes
`define FCR1_PLACE_LOW      2'h0
`define FCR1_PLACE_HIGH     2'h1
`define FCR1_PLACE_SPLIT    2'h2

// Control bits in the control register
`define FCR1_CTRL_MRST      0
`define FCR1_CTRL_BUSY      1

// Time for a nonvolatile store, in ns, and its cycle count at 100 MHz
`define FCR1_CLK_NS         10
`define FCR1_NV_STORE_NS    200
`define FCR1_NV_STORE_CYC   (`FCR1_NV_STORE_NS / `FCR1_CLK_NS)

`endif

// ==== core/fcr1_sync.v ====
// Two flip-flop synchroniser for levels from pins.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps

module fcr1_sync #(
    parameter W = 1
) (
    input  wire         clk,      // System clock
    input  wire         rst_b,    // Async reset, active low
    input  wire [W-1:0] d,        // Asynchronous level in
    input  wire [W-1:0] rst_val,  // Unused-at-reset marker width holder
    output wire [W-1:0] q         // Synchronised level out
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // Two stages; only the second stage is read
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= {W{1'b1}};
            sync_r <= {W{1'b1}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule // fcr1_sync

// ==== core/fcr1_place.v ====
// Decode of sector placement and protection origin.
// Assumes settings come from the volatile configuration copy.
`timescale 1ns/1ps
`include "fcr1_map.vh"

module fcr1_place (
    input  wire       split_sel,    // Split parameter sectors
    input  wire       block_top,    // Parameter block location
    input  wire       orig_bottom,  // Protection origin select
    output reg  [1:0] place,        // Placement code
    output wire       prot_bottom,  // Legacy protection from bottom half
    output wire       readable_low  // Low range readable before password
);

    // Split wins over top/bottom
    always @* begin
        if (split_sel) begin
            place = `FCR1_PLACE_SPLIT;
        end else if (block_top) begin
            place = `FCR1_PLACE_HIGH;
        end else begin
            place = `FCR1_PLACE_LOW;
        end
    end

    // Protection origin steers legacy field and readable range
    assign prot_bottom  = orig_bottom;
    assign readable_low = orig_bottom;

endmodule // fcr1_place

// ==== core/fcr1_regs.v ====
// First configuration register with nonvolatile and volatile copies.
// Assumes a plain register port on clk; pins pass two flip-flops first.
//
// Summary of operation
// - Second status contents valid only while the ready/busy flag reads 0.
// - Split select 0 groups 4KB sectors; 1 splits them across both ends.
// - Placement: 00 low, 01 high, 1x split.
// - Location bit places block at lowest or highest large sector.
// - Protection origin 0 applies legacy field from top, 1 from bottom.
// - Protection origin picks range readable before password entry.
// - Permanent lock blocks changes of guarded bits; lock only sets.
// - Unlocked: guarded nonvolatile bits writable, volatile read-only; locked: both fixed.
// - Temporary lock writable only volatile; cleared by power-up or reset.
// - Temporary lock freezes guarded settings until next power-up or line-3 reset.
// - Quad select 1 turns write-protect and reset pins into data lines.
// - Quad transfers keep data on all four lines.
// - Multiplexed reset with quad: low line 3 while deselected resets.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "fcr1_map.vh"

module fcr1_regs #(
    parameter STORE_CYC = `FCR1_NV_STORE_CYC
) (
    input  wire       clk,          // System clock, 100 MHz
    input  wire       rst_b,        // Power-up reset, async, active low
    input  wire [3:0] addr,         // Register address
    input  wire [7:0] wdata,        // Write data
    input  wire       wr,           // Write strobe
    input  wire       rd,           // Read strobe
    output reg  [7:0] rdata,        // Read data, cycle after rd
    input  wire       cs_b,         // Chip select pin, active low
    input  wire       line3_in,     // Data line 3 pin level
    input  wire       wp_b,         // Write-protect pin, active low
    output wire       quad_mode,    // Four-bit data width active
    output wire       wp_is_data,   // Write-protect pin is data line 2
    output wire       hw_reset,     // Hardware reset pulse from line 3
    output wire       write_prot,   // Write-protect pin in effect
    output wire [1:0] sector_place, // Parameter sector placement
    output wire       prot_bottom,  // Legacy protection from bottom
    output wire       readable_low, // Low range readable before password
    output wire [2:0] legacy_prot,  // Effective legacy protection field
    output wire       ready_busy,   // Busy during store or reset
    output wire       status2_ok    // Second status register valid
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    reg  [7:0] nv_r;
    reg  [7:0] nv_nxt;
    reg  [7:0] vol_r;
    reg  [7:0] vol_nxt;
    reg  [2:0] legacy_r;
    reg  [2:0] legacy_nv_r;
    reg        mrst_en_r;
    reg        load_r;
    reg        rst_pend_r;
    reg  [15:0] busy_cnt_r;
    wire       cs_s;
    wire       line3_s;
    wire       wp_s;
    wire       locked;
    wire       busy;
    wire       line3_rst;

    // Guarded bits fixed by either lock
    function is_locked;
        input [7:0] v;
        begin
            is_locked = v[`FCR1_BIT_PLOCK] | v[`FCR1_BIT_TLOCK];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    fcr1_sync #(
        .W(3)
    ) u_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .d       ({cs_b, line3_in, wp_b}),
        .rst_val (3'h7),
        .q       ({cs_s, line3_s, wp_s})
    );

    ////////////////////////////////////////////////////////////////////
    // Lock state and busy
    assign locked = is_locked(vol_r) | nv_r[`FCR1_BIT_PLOCK];
    assign busy   = (busy_cnt_r != 16'h0000) | load_r | rst_pend_r;

    // Hardware reset from line 3 only in quad mode when deselected
    assign line3_rst = mrst_en_r & vol_r[`FCR1_BIT_QUAD] & cs_s & ~line3_s;

    ////////////////////////////////////////////////////////////////////
    // Nonvolatile copy next value
    always @* begin
        nv_nxt = nv_r;
        if (wr && !busy && addr == `FCR1_ADDR_NV) begin
            // Quad bit always writable; temporary lock never
            nv_nxt = (nv_r & ~`FCR1_NV_FREE_MASK) | (wdata & `FCR1_NV_FREE_MASK);
            if (!locked) begin
                nv_nxt = (nv_nxt & ~`FCR1_LOCKED_MASK)
                       | (wdata & `FCR1_LOCKED_MASK);
            end
            // Permanent lock only sets, even when already locked
            nv_nxt[`FCR1_BIT_PLOCK] = nv_r[`FCR1_BIT_PLOCK] | wdata[`FCR1_BIT_PLOCK];
            // Reserved bits held at zero
            nv_nxt[`FCR1_BIT_RSV7] = 1'b0;
            nv_nxt[`FCR1_BIT_RSV3] = 1'b0;
            nv_nxt[`FCR1_BIT_TLOCK] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Volatile copy next value
    always @* begin
        vol_nxt = vol_r;
        if (load_r) begin
            // Load from nonvolatile copy, temporary lock cleared
            vol_nxt = nv_r;
            vol_nxt[`FCR1_BIT_TLOCK] = 1'b0;
        end else if (wr && !busy && addr == `FCR1_ADDR_VOL) begin
            // Guarded bits read-only in the volatile copy
            vol_nxt = (vol_r & ~`FCR1_VOL_WR_MASK) | (wdata & `FCR1_VOL_WR_MASK);
            // Temporary lock cannot be cleared by software once set
            vol_nxt[`FCR1_BIT_TLOCK] = vol_r[`FCR1_BIT_TLOCK]
                                     | wdata[`FCR1_BIT_TLOCK];
        end else if (wr && !busy && addr == `FCR1_ADDR_NV) begin
            // Nonvolatile changes mirror into the working copy
            vol_nxt = (nv_nxt & ~`FCR1_TLOCK_MASK) | (vol_r & `FCR1_TLOCK_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers; power-up reset then load
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_r   <= `FCR1_RST_CFG;
            vol_r  <= `FCR1_RST_CFG;
            load_r <= 1'b1;
        end else begin
            nv_r   <= nv_nxt;
            vol_r  <= vol_nxt;
            load_r <= line3_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Legacy protection field, guarded by the locks
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            legacy_r    <= `FCR1_RST_LEGACY;
            legacy_nv_r <= `FCR1_RST_LEGACY;
        end else if (load_r) begin
            legacy_r <= legacy_nv_r;
        end else if (wr && !busy && addr == `FCR1_ADDR_LEGACY && !locked) begin
            legacy_r    <= wdata[2:0];
            legacy_nv_r <= wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Store timer, reset pending and control bits
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_r <= 16'h0000;
            rst_pend_r <= 1'b0;
            mrst_en_r  <= 1'b0;
        end else begin
            rst_pend_r <= line3_rst;
            if (line3_rst) begin
                busy_cnt_r <= 16'h0000;
                mrst_en_r  <= 1'b0;
            end else if (wr && !busy && (addr == `FCR1_ADDR_NV
                                       || addr == `FCR1_ADDR_LEGACY)) begin
                busy_cnt_r <= STORE_CYC[15:0];
            end else if (busy_cnt_r != 16'h0000) begin
                busy_cnt_r <= busy_cnt_r - 16'h0001;
            end
            if (wr && !busy && addr == `FCR1_ADDR_CTRL) begin
                mrst_en_r <= wdata[`FCR1_CTRL_MRST];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after rd
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `FCR1_ADDR_NV:     rdata <= nv_r;
                `FCR1_ADDR_VOL:    rdata <= vol_r;
                `FCR1_ADDR_LEGACY: rdata <= {5'h00, legacy_r};
                `FCR1_ADDR_STATUS: rdata <= {6'h00, ~busy, busy};
                `FCR1_ADDR_CTRL:   rdata <= {6'h00, 1'b0, mrst_en_r};
                default:           rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Placement decode
    fcr1_place u_place (
        .split_sel    (vol_r[`FCR1_BIT_SPLIT]),
        .block_top    (vol_r[`FCR1_BIT_PBLOC]),
        .orig_bottom  (vol_r[`FCR1_BIT_PORIG]),
        .place        (sector_place),
        .prot_bottom  (prot_bottom),
        .readable_low (readable_low)
    );

    ////////////////////////////////////////////////////////////////////
    // Pin roles and status outputs
    assign quad_mode  = vol_r[`FCR1_BIT_QUAD];
    assign wp_is_data = vol_r[`FCR1_BIT_QUAD];
    assign write_prot = ~vol_r[`FCR1_BIT_QUAD] & ~wp_s;
    assign hw_reset   = rst_pend_r;
    assign legacy_prot = legacy_r;
    assign ready_busy = busy;
    assign status2_ok = ~busy;

endmodule // fcr1_regs

// ==== verification/fcr1_pins.sv ====
// Pin-side partner: chip select, data line 3 and write protect.
// Assumes the bench asks for a line-3 reset with a one-cycle strobe.
`timescale 1ns/1ps
module fcr1_pins (
    input  wire clk,             // System clock
    input  wire pulse,           // Ask for a line-3 reset
    input  wire wp_in,           // Wanted write-protect level
    output reg  cs_b = 1'b1,     // Kept deselected
    output reg  line3_in = 1'b1, // Data line 3, idles high
    output reg  wp_b = 1'b1      // Write-protect pin
);
    reg [2:0] cnt_r = 3'h0;
    // Line 3 low for five cycles while deselected
    always @(posedge clk) begin
        wp_b     <= wp_in;
        cs_b     <= 1'b1;
        line3_in <= !(pulse || cnt_r != 3'h0);
        cnt_r    <= pulse ? 3'h4 : (cnt_r != 3'h0 ? cnt_r - 3'h1 : 3'h0);
    end
endmodule // fcr1_pins

// ==== verification/fcr1_regs_asserts.sv ====
// Checker on the ports of the first configuration register logic.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ps
module fcr1_regs_asserts #(
    parameter STORE_CYC = 2
) (
    input wire       clk,          // Clock
    input wire       rst_b,        // Reset, active low
    input wire [3:0] addr,         // Address
    input wire       wr,           // Write strobe
    input wire       rd,           // Read strobe
    input wire [7:0] rdata,        // Read data
    input wire       quad_mode,    // Quad width
    input wire       wp_is_data,   // Pin is data line 2
    input wire       hw_reset,     // Line-3 reset
    input wire       write_prot,   // Protect in effect
    input wire [1:0] sector_place, // Placement code
    input wire       prot_bottom,  // Origin at bottom
    input wire       readable_low, // Low range readable
    input wire [2:0] legacy_prot,  // Legacy field
    input wire       ready_busy,   // Busy
    input wire       status2_ok    // Status valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    status_valid_a: assert property (status2_ok == !ready_busy)
        else $error("status valid flag wrong");
    place_code_a: assert property (sector_place != 2'h3)
        else $error("bad placement code");
    read_range_a: assert property (readable_low == prot_bottom)
        else $error("readable range wrong");
    pin_data_a: assert property (wp_is_data == quad_mode)
        else $error("pin role wrong");
    wp_quad_a: assert property (quad_mode |-> !write_prot)
        else $error("protect in quad mode");
    place_hold_a: assert property ($changed(sector_place) |-> $past(wr))
        else $error("placement moved without write");
    legacy_hold_a: assert property ($changed(legacy_prot) |->
        $past(wr) && $past(addr) == 4'h2) else $error("legacy moved");
    store_busy_a: assert property (wr && addr == 4'h0 && !ready_busy |=>
        ready_busy) else $error("no busy after store");
    line3_rst_a: assert property ($rose(hw_reset) |-> $past(quad_mode))
        else $error("reset without quad");
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside slot");
endmodule // fcr1_regs_asserts
bind fcr1_regs fcr1_regs_asserts #(.STORE_CYC(STORE_CYC)) i_chk (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
    .quad_mode(quad_mode), .wp_is_data(wp_is_data), .hw_reset(hw_reset),
    .write_prot(write_prot), .sector_place(sector_place), .prot_bottom(prot_bottom),
    .readable_low(readable_low), .legacy_prot(legacy_prot),
    .ready_busy(ready_busy), .status2_ok(status2_ok));

// ==== verification/flash_config_one_register_logic_test.sv ====
// Bench for the first configuration register logic.
// Assumes fcr1_regs with a short store time and the pin partner beside it.
`timescale 1ns/1ps
module flash_config_one_register_logic_test;
    reg        clk, rst_b, wr, rd, pulse, wp_in, rd_d;
    reg  [3:0] addr;
    reg  [7:0] wdata, r;
    reg  [7:0] exq[$];
    wire [7:0] rdata;
    wire [1:0] sector_place;
    wire [2:0] legacy_prot;
    wire       cs_b, line3_in, wp_b, quad_mode, wp_is_data, hw_reset;
    wire       write_prot, prot_bottom, readable_low, ready_busy, status2_ok;
    integer    failures, checked, i, n;

    fcr1_regs #(.STORE_CYC(2)) i_dut (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cs_b(cs_b), .line3_in(line3_in), .wp_b(wp_b),
        .quad_mode(quad_mode), .wp_is_data(wp_is_data), .hw_reset(hw_reset),
        .write_prot(write_prot), .sector_place(sector_place), .prot_bottom(prot_bottom),
        .readable_low(readable_low), .legacy_prot(legacy_prot),
        .ready_busy(ready_busy), .status2_ok(status2_ok));
    fcr1_pins i_pins (.clk(clk), .pulse(pulse), .wp_in(wp_in), .cs_b(cs_b),
        .line3_in(line3_in), .wp_b(wp_b));

    task chk(input [7:0] seen, input [7:0] want);
        checked = checked + 1;
        if (seen !== want) begin
            failures = failures + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task results;
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wreg(input [3:0] a, input [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task rreg(input [3:0] a, input [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exq.push_back(e);
        @(posedge clk);
        rd   <= 1'b0;
    endtask
    // Bounded wait until the flag reads the wanted level
    task await(input lvl, input hw);
        n = 0;
        @(negedge clk);
        while ((hw ? hw_reset : ready_busy) !== lvl) begin
            n = n + 1;
            if (n > 60) begin
                failures = failures + 1;
                results;
            end
            @(negedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Clock and read monitor
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) if (rd_d === 1'b1) chk(rdata, exq.pop_front());
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_b, wr, rd, pulse, addr, wdata} = 0;
        wp_in = 1'b0;
        failures = 0;
        checked = 0;
        r = $urandom(32'hdff3a68f);
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        await(1'b0, 1'b0);
        rreg(4'h0, 8'h00);
        rreg(4'h1, 8'h00);
        rreg(4'h3, 8'h02);
        chk({7'h0, write_prot}, 8'h01);
        wreg(4'h2, 8'h05);
        await(1'b0, 1'b0);
        wreg(4'h0, 8'h66);
        await(1'b0, 1'b0);
        rreg(4'h0, 8'h66);
        rreg(4'h1, 8'h66);
        chk({sector_place, prot_bottom, quad_mode, wp_is_data, write_prot, 2'h0},
            8'hb8);
        chk({5'h0, legacy_prot}, 8'h05);
        wreg(4'h1, 8'h00);
        rreg(4'h1, 8'h64);
        for (i = 0; i < 4; i = i + 1) begin
            wreg(4'h0, {1'b0, i[1], 3'h0, i[0], 2'h0});
            await(1'b0, 1'b0);
            chk({6'h0, sector_place}, i[1] ? 8'h02 : {7'h0, i[0]});
        end
        wreg(4'h1, 8'h01);
        wreg(4'h0, 8'h22);
        await(1'b0, 1'b0);
        rreg(4'h0, 8'h46);
        wreg(4'h2, 8'h02);
        await(1'b0, 1'b0);
        chk({5'h0, legacy_prot}, 8'h05);
        repeat (4) begin
            r = $urandom;
            wreg(4'h1, r & 8'h77);
            rreg(4'h1, 8'h45 | {6'h0, r[1], 1'b0});
        end
        wreg(4'h1, 8'h02);
        wreg(4'h4, 8'h01);
        rreg(4'h4, 8'h01);
        await(1'b0, 1'b0);
        @(posedge clk);
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        await(1'b1, 1'b1);
        repeat (10) @(posedge clk);
        await(1'b0, 1'b0);
        rreg(4'h1, 8'h46);
        rreg(4'h4, 8'h00);
        wreg(4'h2, 8'h03);
        await(1'b0, 1'b0);
        chk({5'h0, legacy_prot}, 8'h03);
        wreg(4'h0, 8'h56);
        await(1'b0, 1'b0);
        wreg(4'h0, 8'h00);
        await(1'b0, 1'b0);
        rreg(4'h0, 8'h54);
        wreg(4'h2, 8'h00);
        await(1'b0, 1'b0);
        chk({5'h0, legacy_prot}, 8'h03);
        chk({6'h0, prot_bottom, readable_low}, 8'h00);
        // Write-protect pin released while in single width
        @(posedge clk);
        wp_in <= 1'b1;
        repeat (5) @(negedge clk);
        chk({7'h0, write_prot}, 8'h00);
        // Line 3 low with quad set but multiplexed reset disabled
        wreg(4'h1, 8'h03);
        @(posedge clk);
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        repeat (10) @(posedge clk);
        rreg(4'h1, 8'h57);
        // Second power-up reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        await(1'b0, 1'b0);
        rreg(4'h1, 8'h00);
        rreg(4'h3, 8'h02);
        repeat (3) @(posedge clk);
        results;
    end
endmodule // flash_config_one_register_logic_test
